// ### rtl/pmc_ctrl.sv
`timescale 1ns/1ns
`include "pmc_cfg.svh"
// Overview of operation
// - new region needs register rewrite first
// - host avoids deselected half in reduced size
// - deselect 5ns, strobe 10-500ns after sleep low
// - register write cycle at least grade time
// - hold sleep 10us, wait 200us after
module pmc_ctrl #(
  parameter int ADDR_W = 22,
  parameter int ZZMIN_CYC = `PMC_ZZMIN_CYC,
  parameter int REC_CYC = `PMC_REC_CYC
) (
  // one clock domain; reset is asynchronous, active low
  input wire logic clock,
  input wire logic arst_n,
  // user order port: one order at a time, taken with ready high
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_kind,
  input wire logic [7:0] cmd_mode,
  output logic cmd_ready,
  output logic mem_ready,
  output logic [7:0] mode_shadow,
  output logic reduced_active,
  // device pins; every control idles high so the part sits deselected
  output logic chip_enable_n,
  output logic write_enable_n,
  output logic output_enable_n,
  output logic upper_byte_select_n,
  output logic lower_byte_select_n,
  output logic sleep_request_n,
  output logic [ADDR_W-1:0] addr,
  // sleep pin as seen back from the board, not yet synchronised
  input wire logic sleep_request_n_in
);
  // the controller is a single sequencer: it owns every pin, so no pin can
  // change outside the order that the update and sleep timings demand.
  // timing counts are rounded up from the least times, so every wait errs long.
  // trade-off: one shared down counter serves all waits, which keeps the area
  // small but means only one timed wait can run at a time.
  // limitation: only the update and sleep sequences are made, no array access.
  // all state lives in one packed struct, filled by one comb and one ff
  typedef struct packed {
    // sequencer position
    pmc_pkg::pmc_state_t st;
    // shared down counter for every timed wait
    logic [`PMC_CNT_W-1:0] cnt;
    // last mode word programmed into the part
    logic [7:0] mode;
    // chip enable pin, active low
    logic ce_n;
    // write strobe pin, active low
    logic we_n;
    // sleep request pin, active low
    logic zz_n;
    // user side may hand over an order
    logic rdy;
    // array may be accessed by the user
    logic mrdy;
    // reduced-size mode in force
    logic red;
    // address pins, carry the mode word
    logic [ADDR_W-1:0] a;
  } pmc_st_t;
  pmc_st_t s_r, s_nxt;
  logic zz_seen; // pin readback after synchroniser
  // the readback lags the pin by a few cycles; waits on it only ever lengthen

  // the pin readback lets us see the sleep level really reached the device
  pmc_sync u_sync (
    .clock(clock),
    .arst_n(arst_n),
    .din(sleep_request_n_in),
    .dout(zz_seen)
  );

  // sequencer
  // every branch starts from the held state, so unnamed fields other than rdy and cnt keep their value
  always_comb begin
    s_nxt = s_r;
    // ready is a one-cycle decision, made again in every state that grants it
    s_nxt.rdy = 1'b0;
    // the counter runs down on its own and rests at zero
    if (s_r.cnt != `PMC_CNT_ZERO) begin
      s_nxt.cnt = s_r.cnt - `PMC_CNT_ONE;
    end
    unique case (s_r.st)
      // idle: part awake at full or reduced size per the mode word, waiting for an order
      // ready is taken from the flop so an order is never taken twice
      pmc_pkg::PMC_IDLE: begin
        s_nxt.rdy = 1'b1;
        if (cmd_valid && s_r.rdy) begin
          s_nxt.rdy = 1'b0;
          s_nxt.mrdy = 1'b0;
          if (cmd_kind == pmc_pkg::PMC_CMD_SETMODE) begin
            // mode word drives address pins, later reused by every entry
            s_nxt.mode = cmd_mode;
            s_nxt.a = ADDR_W'(cmd_mode);
            s_nxt.ce_n = 1'b1; // deselect first
            s_nxt.cnt = `PMC_CNT_W'(`PMC_CDZZ_CYC);
            s_nxt.st = pmc_pkg::PMC_DESEL;
          end else if (cmd_kind == pmc_pkg::PMC_CMD_SLEEP) begin
            s_nxt.ce_n = 1'b1;
            s_nxt.cnt = `PMC_CNT_W'(`PMC_CDZZ_CYC);
            s_nxt.st = pmc_pkg::PMC_SLEEP;
          end else begin
            s_nxt.rdy = 1'b1;
            s_nxt.mrdy = s_r.mrdy;
          end
        end
      end
      // chip held deselected before the sleep pin may fall
      pmc_pkg::PMC_DESEL: begin
        if (s_r.cnt == `PMC_CNT_ZERO) begin
          s_nxt.zz_n = 1'b0;
          s_nxt.cnt = `PMC_CNT_W'(`PMC_ZZWE_CYC);
          s_nxt.st = pmc_pkg::PMC_ZZLOW;
        end
      end
      pmc_pkg::PMC_ZZLOW: begin
        // least wait is one cycle, far inside the 500ns ceiling
        if (s_r.cnt == `PMC_CNT_ZERO) begin
          s_nxt.ce_n = 1'b0;
          s_nxt.we_n = 1'b0;
          s_nxt.cnt = `PMC_CNT_W'(`PMC_WC_CYC);
          s_nxt.st = pmc_pkg::PMC_WRITE;
        end
      end
      pmc_pkg::PMC_WRITE: begin
        // strobe held for the whole grade cycle time
        if (s_r.cnt == `PMC_CNT_ZERO) begin
          s_nxt.we_n = 1'b1;
          s_nxt.ce_n = 1'b1;
          s_nxt.st = pmc_pkg::PMC_WREND;
        end
      end
      pmc_pkg::PMC_WREND: begin
        // release sleep; reduced size takes hold on this rising edge
        s_nxt.zz_n = 1'b1;
        s_nxt.red = s_r.mode[`PMC_F_SIZE_SEL] & s_r.mode[`PMC_F_PWR_SEL];
        s_nxt.mrdy = 1'b1;
        s_nxt.st = pmc_pkg::PMC_IDLE;
      end
      // deselect first, then drop the sleep pin for the long pulse
      pmc_pkg::PMC_SLEEP: begin
        if (s_r.cnt == `PMC_CNT_ZERO) begin
          s_nxt.zz_n = 1'b0;
          s_nxt.cnt = `PMC_CNT_W'(ZZMIN_CYC);
          s_nxt.st = pmc_pkg::PMC_SLEEPMIN;
        end
      end
      pmc_pkg::PMC_SLEEPMIN: begin
        // wake only after the least pulse and once the pin is seen low
        // orders other than wake are taken with ready high but ignored here
        s_nxt.rdy = (s_r.cnt == `PMC_CNT_ZERO) && !zz_seen;
        if (cmd_valid && s_r.rdy && cmd_kind == pmc_pkg::PMC_CMD_WAKE) begin
          s_nxt.rdy = 1'b0;
          s_nxt.zz_n = 1'b1; // full refresh resumes
          s_nxt.cnt = `PMC_CNT_W'(REC_CYC);
          s_nxt.st = pmc_pkg::PMC_RECOVER;
        end
      end
      pmc_pkg::PMC_RECOVER: begin
        // after deep sleep data is lost; hold off access for recovery
        // the readback must show the pin high again before access is granted
        if (s_r.cnt == `PMC_CNT_ZERO && zz_seen) begin
          s_nxt.red = s_r.mode[`PMC_F_SIZE_SEL] & s_r.mode[`PMC_F_PWR_SEL];
          s_nxt.mrdy = 1'b1;
          s_nxt.st = pmc_pkg::PMC_IDLE;
        end
      end
      // unused state codes fall back to idle
      default: begin
        s_nxt.st = pmc_pkg::PMC_IDLE;
      end
    endcase
  end

  // state register; mode shadow powers up with deep sleep disabled
  // the reset branch holds constants only; control pins idle high, so the part
  // stays deselected and awake while reset is held
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '{st: pmc_pkg::PMC_IDLE, cnt: `PMC_CNT_ZERO, mode: `PMC_MODE_RESET,
               ce_n: 1'b1, we_n: 1'b1, zz_n: 1'b1, rdy: 1'b0, mrdy: 1'b1,
               red: 1'b0, a: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // all outputs come straight from the state flops; byte lanes and OE copy chip enable
  // OE and the byte lanes are ignored by the part during the update, so
  // they simply follow chip enable and never glitch on their own
  // no output is combinational, so board timing sees flop-clean edges
  assign cmd_ready = s_r.rdy;
  assign mem_ready = s_r.mrdy;
  assign mode_shadow = s_r.mode;
  assign reduced_active = s_r.red;
  assign chip_enable_n = s_r.ce_n;
  assign write_enable_n = s_r.we_n;
  assign output_enable_n = s_r.ce_n;
  assign upper_byte_select_n = s_r.ce_n;
  assign lower_byte_select_n = s_r.ce_n;
  assign sleep_request_n = s_r.zz_n;
  assign addr = s_r.a;
endmodule // pmc_ctrl

// ### rtl/pmc_cfg.svh
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH
// clock period in ns
`define PMC_CLK_NS 20
// chip deselect to sleep request low, least, ns
`define PMC_T_CDZZ_NS 5
// sleep request low to write strobe low, least and most, ns
`define PMC_T_ZZWE_MIN_NS 10
`define PMC_T_ZZWE_MAX_NS 500
// register write cycle, least, ns (speed grade)
`define PMC_T_WC_NS 70
// deep sleep pulse width, least, us
`define PMC_T_ZZMIN_US 10
// recovery after sleep release, least, us
`define PMC_T_R_US 200
// derived cycle counts, least times round up
`define PMC_CDZZ_CYC ((`PMC_T_CDZZ_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)
`define PMC_ZZWE_CYC ((`PMC_T_ZZWE_MIN_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)
`define PMC_WC_CYC ((`PMC_T_WC_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)
`define PMC_ZZMIN_CYC ((`PMC_T_ZZMIN_US * 1000 + `PMC_CLK_NS - 1) / `PMC_CLK_NS)
`define PMC_REC_CYC ((`PMC_T_R_US * 1000 + `PMC_CLK_NS - 1) / `PMC_CLK_NS)
// mode register field positions on the address pins
`define PMC_F_REGION_LO 0
`define PMC_F_SIZE_SEL 3
`define PMC_F_PWR_SEL 4
`define PMC_F_TEMP_LO 5
`define PMC_F_PAGE_EN 7
// power-up value of the mode word: deep sleep disabled
`define PMC_MODE_RESET 8'h10
`define PMC_CNT_W 14
`define PMC_CNT_ONE 14'h0001
`define PMC_CNT_ZERO 14'h0000
`endif

// ### rtl/pmc_pkg.sv
package pmc_pkg;
  // sequencer states
  typedef enum logic [3:0] {
    PMC_IDLE, PMC_DESEL, PMC_ZZLOW, PMC_WRITE, PMC_WREND,
    PMC_SLEEP, PMC_SLEEPMIN, PMC_RECOVER
  } pmc_state_t;
  // kinds of order taken from the user port
  typedef enum logic [1:0] {
    PMC_CMD_SETMODE, PMC_CMD_SLEEP, PMC_CMD_WAKE, PMC_CMD_NONE
  } pmc_cmd_t;
endpackage

// ### rtl/pmc_sync.sv
`timescale 1ns/1ns
// three-stage synchroniser; output moves once stages one and two agree
module pmc_sync (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic [2:0] sh;
    logic q;
  } pmc_sync_st_t;
  pmc_sync_st_t s_r, s_nxt;

  // stage 0 is read only by stage 1
  always_comb begin
    s_nxt = s_r;
    s_nxt.sh = {s_r.sh[1:0], din};
    if (s_r.sh[1] == s_r.sh[2]) begin
      s_nxt.q = s_r.sh[2];
    end
  end

  // resets high: sleep request idles deasserted
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '{sh: 3'h7, q: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dout = s_r.q;
endmodule // pmc_sync

// ### tb/pmc_ctrl_asserts.sv
`timescale 1ns/1ns
// pin order checks; counters time the sleep windows
module pmc_ctrl_asserts #(
  parameter int ZZMIN_CYC = 8,
  parameter int REC_CYC = 16
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic mem_ready,
  input wire logic chip_enable_n,
  input wire logic write_enable_n,
  input wire logic sleep_request_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic [13:0] lo_r; // cycles with sleep pin low, saturates so long sleeps never wrap
  logic [13:0] hi_r; // cycles high, saturates so idle never wraps
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lo_r <= 14'h0000;
      hi_r <= 14'h0000;
    end else begin
      lo_r <= sleep_request_n ? 14'h0000 : lo_r + {13'h0000, ~&lo_r};
      hi_r <= !sleep_request_n ? 14'h0000 : hi_r + {13'h0000, ~&hi_r};
    end
  end
  property p_desel; $fell(sleep_request_n) |-> chip_enable_n && $past(chip_enable_n); endproperty
  a_desel: assert property (p_desel) else $error("sleep fell while selected");
  property p_zzwe; $fell(write_enable_n) |-> lo_r >= 14'h0001 && lo_r <= 14'h0019; endproperty
  a_zzwe: assert property (p_zzwe) else $error("strobe outside sleep window");
  property p_wc; $fell(write_enable_n) |-> (!write_enable_n && !chip_enable_n)[*4]; endproperty
  a_wc: assert property (p_wc) else $error("register write too short");
  // the write pulse is excluded: it is the only time the pin returns after a strobe
  property p_zzmin; $rose(sleep_request_n) && $past(write_enable_n, 2) |-> lo_r >= ZZMIN_CYC;
  endproperty
  a_zzmin: assert property (p_zzmin) else $error("sleep pulse too short");
  property p_rec; $rose(mem_ready) && $past(write_enable_n, 3) |-> hi_r >= REC_CYC; endproperty
  a_rec: assert property (p_rec) else $error("memory ready before recovery");
  c_write: cover property ($fell(write_enable_n));
  c_wake: cover property ($rose(mem_ready) && $past(write_enable_n, 3));
  c_long: cover property (lo_r == 14'h0010);
endmodule // pmc_ctrl_asserts
bind pmc_ctrl pmc_ctrl_asserts #(.ZZMIN_CYC(ZZMIN_CYC), .REC_CYC(REC_CYC)) u_chk (.clock,
  .arst_n, .mem_ready, .chip_enable_n, .write_enable_n, .sleep_request_n);

// ### tb/pmc_dev_model.sv
`timescale 1ns/1ns
// behavioural device: mode word, sleep entry, size mode
module pmc_dev_model #(
  parameter int ENTRY_NS = 300 // scaled stand-in for the entry delay
) (
  input wire logic write_enable_n,
  input wire logic sleep_request_n,
  input wire logic [21:0] addr,
  output logic [7:0] mode_r,
  output logic deep_r,
  output logic part_r,
  output logic reduced_r
);
  time fell_t; // last fall of the sleep pin
  initial begin
    mode_r = 8'h10; // deep sleep off at power-up
    deep_r = 1'b0;
    part_r = 1'b0;
    reduced_r = 1'b0;
  end
  // word comes from address pins only; stored word rules all modes
  always @(negedge write_enable_n) if (!sleep_request_n) mode_r = addr[7:0];
  // every fall restarts the entry delay, even one inside an earlier delay
  always @(negedge sleep_request_n) fell_t = $time;
  // entry only once the pin stayed low the whole delay
  always #(10) begin
    if (sleep_request_n === 1'b0 && $time - fell_t >= ENTRY_NS) begin
      part_r = mode_r[4];
      deep_r = !mode_r[4];
    end
  end
  // release: full refresh back, size mode from stored word
  always @(posedge sleep_request_n) begin
    part_r = 1'b0;
    deep_r = 1'b0;
    reduced_r = mode_r[4:3] == 2'b11;
  end
endmodule // pmc_dev_model

// ### tb/pmc_ctrl_tb.sv
`timescale 1ns/1ns
// orders through the user port, device state compared in the model
module pmc_ctrl_tb;
  logic clock, arst_n, cmd_valid, cmd_ready, mem_ready, reduced_active;
  logic ce_n, we_n, zz_n, oe_n, ub_n, lb_n, deep, part, reduced;
  logic [1:0] cmd_kind;
  logic [7:0] cmd_mode, mode_shadow, mode;
  logic [21:0] addr;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  // every temperature code, both power settings, size mode once
  logic [7:0] modes [4] = '{8'h97, 8'h22, 8'h5A, 8'hF6};
  pmc_ctrl #(.ZZMIN_CYC(16), .REC_CYC(16)) dut (.clock, .arst_n, .cmd_valid, .cmd_kind,
    .cmd_mode, .cmd_ready, .mem_ready, .mode_shadow, .reduced_active, .chip_enable_n(ce_n),
    .write_enable_n(we_n), .output_enable_n(oe_n), .upper_byte_select_n(ub_n),
    .lower_byte_select_n(lb_n), .sleep_request_n(zz_n), .addr, .sleep_request_n_in(zz_n));
  pmc_dev_model dev (.write_enable_n(we_n), .sleep_request_n(zz_n), .addr, .mode_r(mode),
    .deep_r(deep), .part_r(part), .reduced_r(reduced));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // a hang ends the run as a mismatch
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // ready looked at mid-cycle so the take edge is never raced
  task automatic wait_rdy(input logic mem);
    @(negedge clock);
    while (cmd_ready !== 1'b1 || (mem && mem_ready !== 1'b1)) @(negedge clock);
  endtask
  task automatic order(input logic [1:0] k, input logic [7:0] m);
    @(posedge clock);
    cmd_kind <= k;
    cmd_mode <= m;
    cmd_valid <= 1'b1;
    wait_rdy(1'b0);
    @(posedge clock);
    cmd_valid <= 1'b0;
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = 2'h3;
    cmd_mode = 8'h00;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    chk(mode, 8'h10);
    chk(mode_shadow, 8'h10);
    order(2'h2, 8'h00); // stray wake ignored while awake
    order(2'h3, 8'h00); // empty order starts no sequence
    wait_rdy(1'b1);
    chk({7'h00, zz_n}, 8'h01);
    chk({5'h00, oe_n, ub_n, lb_n}, 8'h07);
    foreach (modes[i]) begin
      order(2'h0, modes[i]);
      order(2'h1, 8'h00);
      wait_rdy(1'b0);
      chk(mode, modes[i]);
      chk({6'h00, deep, part}, {6'h00, !modes[i][4], modes[i][4]});
      order(2'h2, 8'h00);
      wait_rdy(1'b1);
      chk(mode_shadow, modes[i]);
      chk({6'h00, reduced, reduced_active}, {6'h00, {2{modes[i][4:3] == 2'b11}}});
      chk({7'h00, part}, 8'h00);
    end
    tally_and_finish();
  end
endmodule // pmc_ctrl_tb
